// File: src/ril_top.sv
// Remap lock and SPI input routing register with its pin selection
//
// Contract
// - One-way option refuses clearing a set lock
// - Set lock blocks mapping writes, and unlock too under the one-way option
// - After one-way lock only reset clears it
// - One-way option reads set when unprogrammed
// - Programmed option allows repeated unlocked sessions
// - Bits 13:8 clock select, 5:0 data
// - All-ones code ties input to ground
// - Codes 32-35 virtual pins, lower physical
// - Both fields read/write, reset all ones
// - Bits 15:14 and 7:6 read zero
// - Keys 0x46 then 0x57 precede lock change
// - Locked writes complete but change nothing
// - Lock holds until changed again
// - Shadow compare raises mismatch reset
//
// The strobed register port and the register addresses were chosen for this implementation.
`include "ril_defs.svh"

module ril_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [`RIL_ADDR_W-1:0] reg_addr,
  input wire logic [`RIL_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`RIL_DATA_W-1:0] reg_rdata_q,
  // Configuration fuse
  input wire logic one_way_lock_cfg,
  // Pin sources
  input wire logic [`RIL_NUM_PHYS-1:0] remappable_pin,
  input wire logic [`RIL_NUM_VIRT-1:0] virtual_pin,
  // Routed SPI inputs
  output logic spi_clock_input,
  output logic spi_data_input,
  // Lock state and mismatch reset request
  output logic map_lock_bit_q,
  output logic cfg_mismatch_rst_q
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  //////////////////////////////////////////////////////////////////////////

  ril_pkg::ril_ulk_state_t ulk_q; // Unlock sequence state
  ril_pkg::ril_ulk_state_t ulk_d; // Its next value
  logic one_way_q; // Captured one-way option
  logic cfg_taken_q; // Option has been captured
  logic [`RIL_SEL_W-1:0] clk_sel_q; // Clock input selection
  logic [`RIL_SEL_W-1:0] data_sel_q; // Data input selection
  logic [`RIL_SEL_W-1:0] clk_shadow_q; // Shadow of clock selection
  logic [`RIL_SEL_W-1:0] data_shadow_q; // Shadow of data selection
  logic osc_wr; // Write to oscillator control
  logic route_wr; // Write to routing register
  logic route_wr_ok; // Routing write allowed
  logic lock_req; // Lock value asked for
  logic lock_clear_refused; // Clear blocked by one-way option
  logic lock_d; // Next lock value
  logic [`RIL_DATA_W-1:0] rdata_d; // Next read data
  logic [`RIL_SEL_W-1:0] sel_w [2]; // Selections per channel
  logic [1:0] routed_w; // Routed levels per channel

  //////////////////////////////////////////////////////////////////////////
  // Write decode
  //////////////////////////////////////////////////////////////////////////

  // Strobes qualified by address
  assign osc_wr = reg_wr && (reg_addr == `RIL_OFS_OSC_CTRL);
  assign route_wr = reg_wr && (reg_addr == `RIL_OFS_SPI_ROUTE);

  // Mapping writes only land while unlocked; others are silently dropped
  assign route_wr_ok = route_wr && !map_lock_bit_q;

  //////////////////////////////////////////////////////////////////////////
  // One-way option capture
  //////////////////////////////////////////////////////////////////////////

  // Reset gives the unprogrammed value; fuse is caught once after release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      one_way_q <= `RIL_ONE_WAY_RESET;
      cfg_taken_q <= 1'b0;
    end else if (!cfg_taken_q) begin
      one_way_q <= one_way_lock_cfg;
      cfg_taken_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Unlock sequence
  //////////////////////////////////////////////////////////////////////////

  // Key detection on oscillator control writes; writes to other registers leave it unchanged
  always_comb begin
    ulk_d = ulk_q;
    if (osc_wr) begin
      case (ulk_q)
        ril_pkg::RIL_ULK_IDLE: begin
          // One-way lock held: the sequence never starts
          if (reg_wdata[7:0] == `RIL_KEY_FIRST &&
              !(one_way_q && map_lock_bit_q)) begin
            ulk_d = ril_pkg::RIL_ULK_KEY1;
          end
        end
        ril_pkg::RIL_ULK_KEY1: begin
          if (reg_wdata[7:0] == `RIL_KEY_SECOND) begin
            ulk_d = ril_pkg::RIL_ULK_ARMED;
          end else begin
            ulk_d = ril_pkg::RIL_ULK_IDLE;
          end
        end
        ril_pkg::RIL_ULK_ARMED: begin
          // The single lock operation consumes the arming
          ulk_d = ril_pkg::RIL_ULK_IDLE;
        end
        default: begin
          ulk_d = ril_pkg::RIL_ULK_IDLE;
        end
      endcase
    end
  end

  // Sequence state register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ulk_q <= ril_pkg::RIL_ULK_IDLE;
    end else begin
      ulk_q <= ulk_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Map lock bit
  //////////////////////////////////////////////////////////////////////////

  // Lock value carried by the armed write
  assign lock_req = reg_wdata[`RIL_LOCK_BIT];

  // One-way option forbids clearing once set
  assign lock_clear_refused = one_way_q && map_lock_bit_q;

  // Change only on the armed write; otherwise hold
  always_comb begin
    lock_d = map_lock_bit_q;
    if (osc_wr && ulk_q == ril_pkg::RIL_ULK_ARMED) begin
      if (lock_req) begin
        lock_d = 1'b1;
      end else if (!lock_clear_refused) begin
        lock_d = 1'b0;
      end
    end
  end

  // Lock register; only reset clears a one-way lock
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      map_lock_bit_q <= `RIL_LOCK_RESET;
    end else begin
      map_lock_bit_q <= lock_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // SPI input routing register and its shadow
  //////////////////////////////////////////////////////////////////////////

  // Selection fields, reset to the ground code
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clk_sel_q <= `RIL_SEL_RESET;
      data_sel_q <= `RIL_SEL_RESET;
    end else if (route_wr_ok) begin
      clk_sel_q <= reg_wdata[`RIL_CLK_SEL_HI:`RIL_CLK_SEL_LO];
      data_sel_q <= reg_wdata[`RIL_DATA_SEL_HI:`RIL_DATA_SEL_LO];
    end
  end

  // Shadow copies follow only legal writes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clk_shadow_q <= `RIL_SEL_RESET;
      data_shadow_q <= `RIL_SEL_RESET;
    end else if (route_wr_ok) begin
      clk_shadow_q <= reg_wdata[`RIL_CLK_SEL_HI:`RIL_CLK_SEL_LO];
      data_shadow_q <= reg_wdata[`RIL_DATA_SEL_HI:`RIL_DATA_SEL_LO];
    end
  end

  // Continuous compare; a disturbed cell asks for a reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_mismatch_rst_q <= 1'b0;
    end else begin
      cfg_mismatch_rst_q <= (clk_sel_q != clk_shadow_q) ||
                            (data_sel_q != data_shadow_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Input routing, one mux per SPI input
  //////////////////////////////////////////////////////////////////////////

  // Channel 0 is the clock input, channel 1 the data input
  assign sel_w[0] = clk_sel_q;
  assign sel_w[1] = data_sel_q;

  // One selector per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_route
      ril_sel_mux u_mux (
        .mclk(mclk),
        .rst_b(rst_b),
        .sel(sel_w[ch]),
        .phys_pin_in(remappable_pin),
        .virt_pin_in(virtual_pin),
        .routed_q(routed_w[ch])
      );
    end
  endgenerate

  // Outputs come straight from the mux flip-flops
  assign spi_clock_input = routed_w[0];
  assign spi_data_input = routed_w[1];

  //////////////////////////////////////////////////////////////////////////
  // Read path
  //////////////////////////////////////////////////////////////////////////

  // Read mux; unused bits and unmapped offsets read zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        `RIL_OFS_OSC_CTRL: begin
          rdata_d[`RIL_LOCK_BIT] = map_lock_bit_q;
        end
        `RIL_OFS_SPI_ROUTE: begin
          // Bits 15:14 and 7:6 stay zero
          rdata_d[`RIL_CLK_SEL_HI:`RIL_CLK_SEL_LO] = clk_sel_q;
          rdata_d[`RIL_DATA_SEL_HI:`RIL_DATA_SEL_LO] = data_sel_q;
        end
        `RIL_OFS_STATUS: begin
          rdata_d[`RIL_ST_LOCK] = map_lock_bit_q;
          rdata_d[`RIL_ST_ONE_WAY] = one_way_q;
          rdata_d[`RIL_ST_MISMATCH] = cfg_mismatch_rst_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= '0;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic virt_pick; // Virtual pin named by the clock selection
  assign virt_pick = virtual_pin[clk_sel_q[1:0]];

  // Both keys in order, one idle cycle apart, whatever the lock state
  sequence s_keys;
    osc_wr && reg_wdata[7:0] == `RIL_KEY_FIRST
    ##1 !osc_wr ##1 osc_wr && reg_wdata[7:0] == `RIL_KEY_SECOND;
  endsequence
  sequence s_clear_write;
    osc_wr && !reg_wdata[`RIL_LOCK_BIT];
  endsequence

  chk_oneway_no_clear: assert property (
    one_way_q && map_lock_bit_q && osc_wr |=> map_lock_bit_q)
    else $error("one-way lock was cleared");

  chk_locked_route_hold: assert property (
    map_lock_bit_q && route_wr |=> clk_sel_q == $past(clk_sel_q) &&
      data_sel_q == $past(data_sel_q))
    else $error("locked routing register changed");

  chk_lock_reset_only: assert property (
    one_way_q && map_lock_bit_q |-> ##1 map_lock_bit_q[*3])
    else $error("one-way lock released without reset");

  chk_oneway_default: assert property (
    !cfg_taken_q |-> one_way_q)
    else $error("one-way option not set before capture");

  chk_multi_session: assert property (
    !one_way_q && cfg_taken_q ##0 s_keys ##1 !reg_wr
    ##1 s_clear_write |=> !map_lock_bit_q)
    else $error("programmed option refused an unlock");

  chk_route_write: assert property (
    route_wr_ok |=> clk_sel_q == $past(reg_wdata[13:8]) &&
      data_sel_q == $past(reg_wdata[5:0]))
    else $error("routing fields not written");

  chk_ground_tie: assert property (
    clk_sel_q == `RIL_SEL_GND |=> !spi_clock_input)
    else $error("ground code did not give low");

  chk_virtual_route: assert property (
    clk_sel_q >= `RIL_VIRT_BASE && clk_sel_q <= `RIL_VIRT_LAST
    |=> spi_clock_input == $past(virt_pick))
    else $error("virtual pin not routed");

  chk_unused_zero: assert property (
    reg_rd && reg_addr == `RIL_OFS_SPI_ROUTE
    |=> reg_rdata_q[15:14] == 2'b00 && reg_rdata_q[7:6] == 2'b00)
    else $error("unused routing bits read nonzero");

  chk_lock_needs_keys: assert property (
    map_lock_bit_q != $past(map_lock_bit_q)
    |-> $past(ulk_q) == ril_pkg::RIL_ULK_ARMED && $past(osc_wr))
    else $error("lock changed without unlock keys");

  chk_shadow_match: assert property (
    clk_sel_q == clk_shadow_q && data_sel_q == data_shadow_q
    |=> !cfg_mismatch_rst_q)
    else $error("mismatch raised with equal shadows");

endmodule

// File: shared/ril_defs.svh
// Offsets, field positions, keys and reset values of the remap lock block
`ifndef RIL_DEFS_SVH
`define RIL_DEFS_SVH

// Register bus widths
`define RIL_ADDR_W 4
`define RIL_DATA_W 16

// Register offsets (word index on the plain register port)
`define RIL_OFS_OSC_CTRL 4'h0
`define RIL_OFS_SPI_ROUTE 4'h1
`define RIL_OFS_STATUS 4'h2

// Unlock keys written to the low byte of the oscillator control register
`define RIL_KEY_FIRST 8'h46
`define RIL_KEY_SECOND 8'h57

// Map lock bit position inside the oscillator control register
`define RIL_LOCK_BIT 6

// Field positions inside the SPI input routing register
`define RIL_CLK_SEL_HI 13
`define RIL_CLK_SEL_LO 8
`define RIL_DATA_SEL_HI 5
`define RIL_DATA_SEL_LO 0

// Status register bit positions
`define RIL_ST_LOCK 0
`define RIL_ST_ONE_WAY 1
`define RIL_ST_MISMATCH 2

// Selection codes
`define RIL_SEL_W 6
`define RIL_SEL_RESET 6'h3F
`define RIL_SEL_GND 6'h3F
`define RIL_VIRT_BASE 6'h20
`define RIL_VIRT_LAST 6'h23

// Pin counts
`define RIL_NUM_PHYS 32
`define RIL_NUM_VIRT 4

// Reset values
`define RIL_LOCK_RESET 1'b0
`define RIL_ONE_WAY_RESET 1'b1

`endif

// File: shared/ril_pkg.sv
// Types shared by the remap lock block
package ril_pkg;

  // Unlock sequence states, Gray coded from idle up to armed
  typedef enum logic [1:0] {
    RIL_ULK_IDLE = 2'b00,
    RIL_ULK_KEY1 = 2'b01,
    RIL_ULK_ARMED = 2'b11
  } ril_ulk_state_t;

endpackage

// File: src/ril_sel_mux.sv
// One routed peripheral input: picks a pin, a virtual pin or ground
`include "ril_defs.svh"

module ril_sel_mux (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Selection code and sources
  input wire logic [`RIL_SEL_W-1:0] sel,
  input wire logic [`RIL_NUM_PHYS-1:0] phys_pin_in,
  input wire logic [`RIL_NUM_VIRT-1:0] virt_pin_in,
  // Routed input, registered
  output logic routed_q
);

  logic routed_d; // Next routed level

  // Decode the selection code
  always_comb begin
    if (sel < `RIL_VIRT_BASE) begin
      // Physical pin of the same number
      routed_d = phys_pin_in[sel[4:0]];
    end else if (sel <= `RIL_VIRT_LAST) begin
      // Internal virtual pins
      routed_d = virt_pin_in[sel[1:0]];
    end else begin
      // Ground code and codes naming no pin both read low
      routed_d = 1'b0;
    end
  end

  // Register the routed level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      routed_q <= 1'b0;
    end else begin
      routed_q <= routed_d;
    end
  end

endmodule

// File: verification/tb_remap_input_lock_select.sv
// Self-checking testbench for the remap lock and SPI input routing block
`include "ril_defs.svh"

module tb_remap_input_lock_select;
  timeunit 1ns;
  timeprecision 100ps;

  //////////////////////////////////////////////////////////////////////////////
  // Signals towards the design
  logic mclk; // System clock
  logic rst_b; // Active low reset
  logic [3:0] reg_addr; // Register index
  logic [15:0] reg_wdata; // Write data
  logic reg_wr; // Write strobe
  logic reg_rd; // Read strobe
  logic [15:0] reg_rdata_q; // Read data
  logic one_way_lock_cfg; // Configuration fuse
  logic [31:0] remappable_pin; // Physical pin levels
  logic [3:0] virtual_pin; // Virtual pin levels
  logic spi_clock_input; // Routed clock input
  logic spi_data_input; // Routed data input
  logic map_lock_bit_q; // Lock state
  logic cfg_mismatch_rst_q; // Mismatch reset request
  int err_count; // Mismatches seen
  int check_count; // Comparisons made
  int cycles; // Clock cycles since start

  //////////////////////////////////////////////////////////////////////////////
  // Device under test
  ril_top dut (
    .mclk(mclk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .one_way_lock_cfg(one_way_lock_cfg),
    .remappable_pin(remappable_pin),
    .virtual_pin(virtual_pin),
    .spi_clock_input(spi_clock_input),
    .spi_data_input(spi_data_input),
    .map_lock_bit_q(map_lock_bit_q),
    .cfg_mismatch_rst_q(cfg_mismatch_rst_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Clock of 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cuts a hung run short after a generous cycle budget
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      results();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  // Compares a value seen with the value expected
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run
  task automatic results();
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Holds reset for 8 cycles with the given fuse, then lets it settle
  task automatic do_reset(input logic cfg);
    @(posedge mclk);
    rst_b <= 1'b0;
    one_way_lock_cfg <= cfg;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read, data judged in the following cycle
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, exp);
  endtask

  // Key pair followed by the lock update
  task automatic unlock(input logic [15:0] v);
    wr(`RIL_OFS_OSC_CTRL, 16'h0046);
    wr(`RIL_OFS_OSC_CTRL, 16'h0057);
    wr(`RIL_OFS_OSC_CTRL, v);
    #1;
  endtask

  // Level expected on a routed input for a selection code
  function automatic logic exp_route(input int c);
    if (c < 32) begin
      return remappable_pin[c];
    end else if (c < 36) begin
      return virtual_pin[c-32];
    end
    return 1'b0;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Reset values, reserved bits and an unmapped index
  task automatic t_fields();
    rd(`RIL_OFS_SPI_ROUTE, 16'h3F3F);
    rd(`RIL_OFS_STATUS, 16'h0002);
    rd(`RIL_OFS_OSC_CTRL, 16'h0000);
    check({15'h0000, spi_clock_input}, 16'h0000);
    check({15'h0000, spi_data_input}, 16'h0000);
    wr(`RIL_OFS_SPI_ROUTE, 16'hFFFF);
    rd(`RIL_OFS_SPI_ROUTE, 16'h3F3F);
    wr(`RIL_OFS_SPI_ROUTE, 16'h2A15);
    rd(`RIL_OFS_SPI_ROUTE, 16'h2A15);
    wr(4'h7, 16'hFFFF);
    rd(4'h7, 16'h0000);
    rd(`RIL_OFS_SPI_ROUTE, 16'h2A15);
  endtask

  // Every kind of selection code on both routed inputs, both pin levels
  task automatic t_routing();
    int codes[10] = '{0, 5, 31, 32, 33, 34, 35, 36, 62, 63};
    int c;
    int d;
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk);
      remappable_pin <= p ? 32'h5A3C_96E1 : 32'hA5C3_691E;
      virtual_pin <= p ? 4'b1010 : 4'b0101;
      for (int i = 0; i < 10; i++) begin
        c = codes[i];
        d = codes[9-i];
        wr(`RIL_OFS_SPI_ROUTE, {2'b00, c[5:0], 2'b00, d[5:0]});
        repeat (2) @(posedge mclk);
        #1;
        check({15'h0000, spi_clock_input}, {15'h0000, exp_route(c)});
        check({15'h0000, spi_data_input}, {15'h0000, exp_route(d)});
      end
    end
  endtask

  // One-way option: lock taken once, refused to clear, writes ignored
  task automatic t_one_way();
    wr(`RIL_OFS_SPI_ROUTE, 16'h0304);
    wr(`RIL_OFS_OSC_CTRL, 16'h0040);
    #1;
    check({15'h0000, map_lock_bit_q}, 16'h0000);
    unlock(16'h0040);
    check({15'h0000, map_lock_bit_q}, 16'h0001);
    rd(`RIL_OFS_OSC_CTRL, 16'h0040);
    rd(`RIL_OFS_STATUS, 16'h0003);
    wr(`RIL_OFS_SPI_ROUTE, 16'h0506);
    rd(`RIL_OFS_SPI_ROUTE, 16'h0304);
    unlock(16'h0000);
    check({15'h0000, map_lock_bit_q}, 16'h0001);
    wr(`RIL_OFS_OSC_CTRL, 16'h0000);
    rd(`RIL_OFS_OSC_CTRL, 16'h0040);
    do_reset(1'b0);
    check({15'h0000, map_lock_bit_q}, 16'h0000);
    rd(`RIL_OFS_STATUS, 16'h0000);
  endtask

  // Programmed option: repeated sessions, broken and split key sequences
  task automatic t_sessions();
    for (int s = 0; s < 2; s++) begin
      unlock(16'h0040);
      check({15'h0000, map_lock_bit_q}, 16'h0001);
      unlock(16'h0000);
      check({15'h0000, map_lock_bit_q}, 16'h0000);
      wr(`RIL_OFS_SPI_ROUTE, {8'h10 + 8'(s), 8'h21});
      wr(`RIL_OFS_SPI_ROUTE, {8'h22, 8'h11 + 8'(s)});
      rd(`RIL_OFS_SPI_ROUTE, {8'h22, 8'h11 + 8'(s)});
    end
    wr(`RIL_OFS_OSC_CTRL, 16'h0046);
    wr(`RIL_OFS_OSC_CTRL, 16'h0000);
    wr(`RIL_OFS_OSC_CTRL, 16'h0057);
    wr(`RIL_OFS_OSC_CTRL, 16'h0040);
    #1;
    check({15'h0000, map_lock_bit_q}, 16'h0000);
    wr(`RIL_OFS_OSC_CTRL, 16'h0046);
    wr(`RIL_OFS_SPI_ROUTE, 16'h0101);
    wr(`RIL_OFS_OSC_CTRL, 16'h0057);
    wr(`RIL_OFS_OSC_CTRL, 16'h0040);
    #1;
    check({15'h0000, map_lock_bit_q}, 16'h0001);
    rd(`RIL_OFS_SPI_ROUTE, 16'h0101);
    check({15'h0000, cfg_mismatch_rst_q}, 16'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_count = 0;
    check_count = 0;
    cycles = 0;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    one_way_lock_cfg = 1'b1;
    remappable_pin = 32'h0000_0000;
    virtual_pin = 4'h0;
    do_reset(1'b1);
    t_fields();
    t_routing();
    t_one_way();
    t_sessions();
    results();
  end

endmodule
